// ### design/battery_capacity_model.sv
/*
  Capacity model of a fuel gauge: charge accumulation with bias, age scaling,
  curve reconstruction and the parameter registers, reached over APB.
  Assumes conv_tick pulses once per current conversion with current_result
  valid, and temp_result is a signed reading with three fraction bits.

*/
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "battery_defs.svh"

module battery_capacity_model #(
  parameter int SAVE_CYCLES = `SAVE_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  input  wire battery_pkg::apb_req_t   apb_in,
  output battery_pkg::apb_rsp_t        apb_out,
  input  wire logic                    conv_tick,
  input  wire logic signed [15:0]      current_result,
  input  wire logic signed [10:0]      temp_result,
  input  wire logic                    learn_valid,
  input  wire logic [7:0]              learn_scale,
  output logic [15:0]                  charge_count,
  output logic [7:0]                   age_scale,
  output battery_pkg::limits_t         limits,
  output logic [15:0]                  full_now,
  output logic [15:0]                  active_empty_now,
  output logic [15:0]                  standby_empty_now,
  output logic                         params_ready
);
  import battery_pkg::*;

  localparam int ACC_W = 16 + `FRAC_W;
  localparam logic [31:0] SAVE_LAST = 32'(SAVE_CYCLES - 1);

  if (SAVE_CYCLES < 2) begin : g_chk
    $error("SAVE_CYCLES must be at least 2");
  end

  gauge_t             s;
  gauge_t             s_n;
  logic               mem_we;
  logic [4:0]         mem_addr;
  logic [15:0]        mem_wdata;
  logic [15:0]        mem_rdata;
  logic [15:0]        curve_val [`CURVE_CNT];
  logic [15:0]        curve_base [`CURVE_CNT];
  logic signed [7:0]  deg_now;
  logic signed [ACC_W+1:0] acc_sum;
  logic [15:0]        acc_new;
  logic [23:0]        age_next;
  logic [23:0]        age_lim;
  logic [4:0]         bus_idx;
  logic               bus_mapped;
  logic               bus_writable;
  logic               host_mem;

  // Stores one parameter word into the record; shared by load and host writes.
  function automatic gauge_t put_word(gauge_t g, logic [4:0] idx, logic [15:0] d);
    gauge_t r;
    r = g;
    unique case (idx)
      `IDX_ACC:    r.acc = d;
      `IDX_BIAS:   r.bias = d[7:0];
      `IDX_SENSE_CONDUCTANCE:  r.lim.sense_conductance = d[7:0];
      `IDX_CHARGE_VOLTAGE_THRESHOLD:   r.lim.charge_voltage_threshold = d[7:0];
      `IDX_MIN_CHARGE_CURRENT_THRESHOLD:   r.lim.min_charge_current_threshold = d[7:0];
      `IDX_VAE:    r.lim.empty_voltage_threshold = d[7:0];
      `IDX_IAE:    r.lim.empty_current_threshold = d[7:0];
      `IDX_AC:     r.lim.ac = d;
      `IDX_AS:     r.as = d[7:0];
      `IDX_FULL40: r.lim.full40 = d;
      `IDX_AE40:   r.ae40 = d;
      default: begin
        if (idx >= `IDX_SLOPE0 && idx <= `IDX_NV_LAST) begin
          r.slope[4'(idx - `IDX_SLOPE0)] = d[7:0];
        end
      end
    endcase
    return r;
  endfunction : put_word

  param_mem #(
    .AW (5),
    .DW (16)
  ) u_store (
    .clk   (clk),
    .ce    (ce),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Full starts at unity, standby empty at zero, active empty at its fraction.
  assign curve_base[0] = `FULL_NORM;
  assign curve_base[1] = s.ae40;
  assign curve_base[2] = 16'h0000;

  for (genvar c = 0; c < `CURVE_CNT; c++) begin : g_curve
    curve_eval u_curve (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .start     (s.calc_go),
      .deg       (s.deg),
      .base      (curve_base[c]),
      .slopes    (s.slope[`SEG_CNT*c +: `SEG_CNT]),
      .value_reg (curve_val[c])
    );
  end

  assign deg_now = temp_result[10:3];
  assign bus_idx = apb_in.paddr[6:2];
  assign bus_mapped = (apb_in.paddr[11:7] == 5'h00) && (bus_idx <= `IDX_STATUS);
  assign bus_writable = (bus_idx <= `IDX_NV_LAST) && (bus_idx != `IDX_FRAC);

  always_comb begin
    s_n = s;
    s_n.calc_go = 1'b0;
    mem_we = 1'b0;
    mem_addr = s.load_idx;
    mem_wdata = 16'h0000;
    host_mem = 1'b0;
    acc_sum = '0;
    acc_new = s.acc;
    age_next = s.age_cnt;
    age_lim = {3'b000, s.lim.ac, 5'b00000};
    unique case (s.fsm)
      ST_LOAD: begin
        // Store read data arrives one cycle after its address.
        if (s.load_pend) begin
          s_n = put_word(s_n, s.load_addr_d, mem_rdata);
        end
        if (s.load_idx <= `IDX_NV_LAST) begin
          mem_addr = s.load_idx;
          s_n.load_addr_d = s.load_idx;
          s_n.load_idx = s.load_idx + 5'h01;
          s_n.load_pend = 1'b1;
        end else begin
          s_n.load_pend = 1'b0;
          if (!s.load_pend) begin
            s_n.fsm = ST_RUN;
            s_n.deg = deg_now;
            s_n.calc_go = 1'b1;
          end
        end
      end
      ST_RUN: begin
        // A whole-degree step triggers a rebuild; a host write below to any writable register but the count also triggers one.
        if (deg_now != s.deg) begin
          s_n.deg = deg_now;
          s_n.calc_go = 1'b1;
        end
        if (conv_tick) begin
          acc_sum = $signed({2'b00, s.acc, s.frac})
                  + (ACC_W+2)'(current_result)
                  + (ACC_W+2)'($signed(s.bias));
          if (acc_sum < 0) begin
            acc_sum = '0;
          end else if (acc_sum > $signed({2'b00, {ACC_W{1'b1}}})) begin
            acc_sum = $signed({2'b00, {ACC_W{1'b1}}});
          end
          acc_new = acc_sum[ACC_W-1:`FRAC_W];
          s_n.acc = acc_new;
          s_n.frac = acc_sum[`FRAC_W-1:0];
          if (acc_new < s.acc) begin
            age_next = s.age_cnt + 24'(s.acc - acc_new);
          end
          if (s.lim.ac != 16'h0000 && age_next >= age_lim) begin
            age_next = age_next - age_lim;
            if (s.as > `AS_MIN) begin
              s_n.as = s.as - 8'h01;
            end
          end
          s_n.age_cnt = age_next;
        end
        if (learn_valid) begin
          s_n.as = learn_scale;
        end
        // Host access: one wait state, write committed when pready is seen.
        if (apb_in.psel && apb_in.penable) begin
          if (!s.rsp.pready) begin
            s_n.rsp.pready = 1'b1;
            s_n.rsp.pslverr = !bus_mapped;
            s_n.rsp.prdata = 32'h0000_0000;
            unique case (bus_idx)
              `IDX_ACC:     s_n.rsp.prdata[15:0] = s.acc;
              `IDX_FRAC:    s_n.rsp.prdata[`FRAC_W-1:0] = s.frac;
              `IDX_BIAS:    s_n.rsp.prdata[7:0] = s.bias;
              `IDX_SENSE_CONDUCTANCE:   s_n.rsp.prdata[7:0] = s.lim.sense_conductance;
              `IDX_CHARGE_VOLTAGE_THRESHOLD:    s_n.rsp.prdata[7:0] = s.lim.charge_voltage_threshold;
              `IDX_MIN_CHARGE_CURRENT_THRESHOLD:    s_n.rsp.prdata[7:0] = s.lim.min_charge_current_threshold;
              `IDX_VAE:     s_n.rsp.prdata[7:0] = s.lim.empty_voltage_threshold;
              `IDX_IAE:     s_n.rsp.prdata[7:0] = s.lim.empty_current_threshold;
              `IDX_AC:      s_n.rsp.prdata[15:0] = s.lim.ac;
              `IDX_AS:      s_n.rsp.prdata[7:0] = s.as;
              `IDX_FULL40:  s_n.rsp.prdata[15:0] = s.lim.full40;
              `IDX_AE40:    s_n.rsp.prdata[15:0] = s.ae40;
              `IDX_FULLNOW: s_n.rsp.prdata[15:0] = curve_val[0];
              `IDX_AENOW:   s_n.rsp.prdata[15:0] = curve_val[1];
              `IDX_SENOW:   s_n.rsp.prdata[15:0] = curve_val[2];
              `IDX_STATUS:  s_n.rsp.prdata[8:0] = {1'b1, s.deg};
              default: begin
                if (bus_idx >= `IDX_SLOPE0 && bus_idx <= `IDX_NV_LAST) begin
                  s_n.rsp.prdata[7:0] = s.slope[4'(bus_idx - `IDX_SLOPE0)];
                end
              end
            endcase
          end else begin
            s_n.rsp.pready = 1'b0;
            s_n.rsp.pslverr = 1'b0;
            if (apb_in.pwrite && bus_mapped && bus_writable) begin
              // Host writes last so they override same-cycle device updates.
              s_n = put_word(s_n, bus_idx, apb_in.pwdata[15:0]);
              if (bus_idx == `IDX_ACC) begin
                s_n.frac = '0;
              end else begin
                host_mem = 1'b1;
                mem_we = 1'b1;
                mem_addr = bus_idx;
                mem_wdata = apb_in.pwdata[15:0];
                s_n.calc_go = 1'b1;
              end
            end
          end
        end else begin
          s_n.rsp.pready = 1'b0;
          s_n.rsp.pslverr = 1'b0;
        end
        // A pending save yields to a host write and retries next cycle.
        if (s.save_pend && !host_mem) begin
          mem_we = 1'b1;
          mem_addr = `IDX_AS;
          mem_wdata = {8'h00, s.as};
          s_n.save_pend = 1'b0;
        end
        if (s.save_cnt >= SAVE_LAST) begin
          s_n.save_cnt = 32'h0000_0000;
          s_n.save_pend = 1'b1;
        end else begin
          s_n.save_cnt = s.save_cnt + 32'h0000_0001;
        end
      end
      default: begin
        s_n.fsm = ST_LOAD;
        s_n.load_idx = `IDX_NV_FIRST;
        s_n.load_pend = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.fsm <= ST_LOAD;
      s.load_idx <= `IDX_NV_FIRST;
      s.as <= `AS_RESET;
    end else if (ce) begin
      s <= s_n;
    end
  end

  assign apb_out = s.rsp;
  assign charge_count = s.acc;
  assign age_scale = s.as;
  assign limits = s.lim;
  assign full_now = curve_val[0];
  assign active_empty_now = curve_val[1];
  assign standby_empty_now = curve_val[2];
  assign params_ready = (s.fsm == ST_RUN);

endmodule : battery_capacity_model

// ### design/battery_defs.svh
/*
  Offsets, field constants, reset values and timing counts of the capacity model.
  Assumes it is included by bare name from the package and every design module.
*/
`ifndef BATTERY_DEFS_SVH
`define BATTERY_DEFS_SVH

// Word indices of the registers; the byte address is four times the index.
`define IDX_ACC       5'h00
`define IDX_FRAC      5'h01
`define IDX_BIAS      5'h02
`define IDX_SENSE_CONDUCTANCE     5'h03
`define IDX_CHARGE_VOLTAGE_THRESHOLD      5'h04
`define IDX_MIN_CHARGE_CURRENT_THRESHOLD      5'h05
`define IDX_VAE       5'h06
`define IDX_IAE       5'h07
`define IDX_AC        5'h08
`define IDX_AS        5'h09
`define IDX_FULL40    5'h0a
`define IDX_AE40      5'h0b
`define IDX_SLOPE0    5'h0c
`define IDX_FULLNOW   5'h18
`define IDX_AENOW     5'h19
`define IDX_SENOW     5'h1a
`define IDX_STATUS    5'h1b
`define IDX_NV_FIRST  5'h02
`define IDX_NV_LAST   5'h17

`define AS_RESET      8'h80
`define AS_MIN        8'h3f
`define FULL_NORM     16'h4000
`define CURVE_MAX     24'sh007fff
`define SEG_DEG       9'sd10
`define SEG_CNT       4
`define CURVE_CNT     3
`define FRAC_W        12
`define AGE_SHIFT     5

`define CLK_MHZ       200
`define SAVE_PERIOD_MS 1000
`define SAVE_CYCLES   (`SAVE_PERIOD_MS * 1000 * `CLK_MHZ)

`endif

// ### design/battery_pkg.sv
/*
  Types shared by the capacity model: bus carriers, limits and the state record.
  Assumes battery_defs.svh is on the include path.
*/
`include "battery_defs.svh"

package battery_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0]  sense_conductance;
    logic [7:0]  charge_voltage_threshold;
    logic [7:0]  min_charge_current_threshold;
    logic [7:0]  empty_voltage_threshold;
    logic [7:0]  empty_current_threshold;
    logic [15:0] ac;
    logic [15:0] full40;
  } limits_t;

  typedef struct packed {
    fsm_t                         fsm;
    logic [4:0]                   load_idx;
    logic [4:0]                   load_addr_d;
    logic                         load_pend;
    logic [15:0]                  acc;
    logic [`FRAC_W-1:0]           frac;
    logic [7:0]                   bias;
    logic [7:0]                   as;
    logic [15:0]                  ae40;
    logic [`CURVE_CNT*`SEG_CNT-1:0][7:0] slope;
    limits_t                      lim;
    logic [23:0]                  age_cnt;
    logic [31:0]                  save_cnt;
    logic                         save_pend;
    logic signed [7:0]            deg;
    logic                         calc_go;
    apb_rsp_t                     rsp;
  } gauge_t;

endpackage : battery_pkg

// ### design/param_mem.sv
/*
  Small parameter store standing in for the nonvolatile block, one port.
  Assumes one write or one read per enabled cycle; read data is registered.
*/
`timescale 1ns/10ps
`include "battery_defs.svh"

module param_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  if (AW < 5 || DW < 16) begin : g_chk
    $error("param_mem too small for the parameter map");
  end

  // Blank store: everything zero except an unaged scale factor.
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = '0;
    end
    mem[`IDX_AS] = DW'(`AS_RESET);
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule : param_mem

// ### design/curve_eval.sv
/*
  Rebuilds one piecewise-linear capacity curve at a whole-degree temperature.
  Assumes base and slopes are stable while start is high; value is registered.
*/
`timescale 1ns/10ps
`include "battery_defs.svh"

module curve_eval (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   start,
  input  wire logic signed [7:0]      deg,
  input  wire logic [15:0]            base,
  input  wire logic [`SEG_CNT-1:0][7:0] slopes,
  output logic [15:0]                 value_reg
);

  logic signed [23:0] sum;

  // Degrees of segment k lying between deg and the forty-degree end.
  function automatic logic signed [8:0] covered(logic signed [7:0] d, int k);
    logic signed [8:0] hi;
    logic signed [8:0] lo;
    hi = 9'(`SEG_DEG * (k + 1));
    lo = 9'(`SEG_DEG * k);
    if (d >= hi) begin
      covered = 9'sd0;
    end else if (k == 0 || d > lo) begin
      covered = hi - 9'(d);
    end else begin
      covered = `SEG_DEG;
    end
  endfunction : covered

  always_comb begin
    sum = 24'($signed({8'h00, base}));
    for (int k = 0; k < `SEG_CNT; k++) begin
      sum = sum - 24'($signed(slopes[k])) * 24'(covered(deg, k));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_reg <= 16'h0000;
    end else if (ce && start) begin
      if (sum < 0) begin
        value_reg <= 16'h0000;
      end else if (sum > `CURVE_MAX) begin
        value_reg <= 16'(`CURVE_MAX);
      end else begin
        value_reg <= sum[15:0];
      end
    end
  end

endmodule : curve_eval

// ### test/capacity_checker.sv
/*
  Port-level checks of the capacity model, bound into every instance.
  Assumes ce stays high and the host waits for params_ready before access.
*/
`timescale 1ns/10ps
module capacity_checker import battery_pkg::*; #(
  parameter int SAVE_CYCLES = 16
) (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  ce,
  input wire battery_pkg::apb_req_t apb_in,
  input wire battery_pkg::apb_rsp_t apb_out,
  input wire logic                  conv_tick,
  input wire logic signed [15:0]    current_result,
  input wire logic signed [10:0]    temp_result,
  input wire logic                  learn_valid,
  input wire logic [7:0]            learn_scale,
  input wire logic [15:0]           charge_count,
  input wire logic [7:0]            age_scale,
  input wire battery_pkg::limits_t  limits,
  input wire logic [15:0]           full_now,
  input wire logic [15:0]           active_empty_now,
  input wire logic [15:0]           standby_empty_now,
  input wire logic                  params_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RESET_STATE: assert property ($fell(sys_rst) |->
    age_scale == 8'h80 && charge_count == 16'h0000 && !params_ready)
    else $error("reset state of scale or count wrong");
  AST_LOAD_STALL: assert property (!params_ready |-> !apb_out.pready)
    else $error("answer given before parameter load");
  AST_ONE_WAIT: assert property (
    apb_in.psel && apb_in.penable && params_ready && !apb_out.pready |=> apb_out.pready)
    else $error("access not answered after one wait state");
  AST_READY_PULSE: assert property (apb_out.pready |=> !apb_out.pready)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (apb_out.pslverr |-> apb_out.pready)
    else $error("pslverr without pready");
  AST_COUNT_HOLDS: assert property (
    params_ready && !conv_tick && !apb_in.psel |=> $stable(charge_count))
    else $error("charge count moved without a conversion");
  AST_SCALE_STEP: assert property (
    params_ready && !learn_valid && !apb_in.psel |=>
    age_scale == $past(age_scale) || age_scale == $past(age_scale) - 8'h01)
    else $error("age scale moved by more than one step");
  AST_ABOVE_FORTY: assert property (
    (params_ready && $signed(temp_result[10:3]) > 8'sd39) [*4] |->
    full_now == 16'h4000 && standby_empty_now == 16'h0000)
    else $error("curves not held at forty degree points");
  AST_CURVE_STEADY: assert property (
    (params_ready && !apb_in.psel && $stable(temp_result[10:3])) [*4] |=>
    $stable(full_now) && $stable(active_empty_now))
    else $error("curve changed within one whole degree");
endmodule : capacity_checker

bind battery_capacity_model capacity_checker #(.SAVE_CYCLES(SAVE_CYCLES)) capacity_checker_i (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .apb_in(apb_in), .apb_out(apb_out),
  .conv_tick(conv_tick), .current_result(current_result), .temp_result(temp_result),
  .learn_valid(learn_valid), .learn_scale(learn_scale), .charge_count(charge_count),
  .age_scale(age_scale), .limits(limits), .full_now(full_now),
  .active_empty_now(active_empty_now), .standby_empty_now(standby_empty_now),
  .params_ready(params_ready));

// ### test/host_apb_model.sv
/*
  Host processor on the register port: an APB master with one transfer task.
  Assumes one caller at a time; the bench timeout ends a wait that never ends.
*/
`timescale 1ns/10ps
module host_apb_model (
  input  wire battery_pkg::apb_rsp_t apb_out,
  input  wire logic                  clk,
  output battery_pkg::apb_req_t      apb_in
);
  import battery_pkg::*;
  initial apb_in = '0;
  // The slave may stall during parameter load, so the request is held until pready.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_in.penable <= 1'b1;
    do @(posedge clk); while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in <= '0;
  endtask : xfer
endmodule : host_apb_model

// ### test/test_battery_capacity_model.sv
/*
  Self-checking bench: register and curve rows, then bias, saturation,
  aging, learning and save-restore cases.
  Assumes design files, checker and host model are compiled before it.
*/
`timescale 1ns/10ps
module test_battery_capacity_model;
  import battery_pkg::*;
  typedef struct packed {
    logic        crv;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  localparam int SAVE = 16;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               ce = 1'b1;
  logic               conv_tick = 1'b0;
  logic signed [15:0] current_result = 16'sh0000;
  logic signed [10:0] temp_result = 11'sh000;
  logic               learn_valid = 1'b0;
  logic [7:0]         learn_scale = 8'h00;
  apb_req_t           apb_in;
  apb_rsp_t           apb_out;
  limits_t            limits;
  logic [15:0]        charge_count, full_now, ae_now, se_now;
  logic [7:0]         age_scale;
  logic               params_ready, err;
  logic [31:0]        rd;
  int                 err_count = 0;
  int                 tests_run = 0;
  row_t rows [21] = '{
    '{1'b0, 12'h008, 32'h80, 32'h80},
    '{1'b0, 12'h00c, 32'h32, 32'h32},
    '{1'b0, 12'h010, 32'hd7, 32'hd7},
    '{1'b0, 12'h014, 32'h1ff, 32'hff},
    '{1'b0, 12'h018, 32'h9a, 32'h9a},
    '{1'b0, 12'h01c, 32'h1e, 32'h1e},
    '{1'b0, 12'h020, 32'h1, 32'h1},
    '{1'b0, 12'h024, 32'h7a, 32'h7a},
    '{1'b0, 12'h028, 32'h41b, 32'h41b},
    '{1'b0, 12'h02c, 32'h100, 32'h100},
    '{1'b0, 12'h030, 32'h1, 32'h1},
    '{1'b0, 12'h034, 32'h2, 32'h2},
    '{1'b0, 12'h038, 32'h3, 32'h3},
    '{1'b0, 12'h03c, 32'h4, 32'h4},
    '{1'b1, 12'h140, 32'h0, 32'h4000},
    '{1'b1, 12'h118, 32'h0, 32'h3fec},
    '{1'b1, 12'h0c8, 32'h0, 32'h3fc9},
    '{1'b1, 12'h0cc, 32'h0, 32'h3fc9},
    '{1'b1, 12'h000, 32'h0, 32'h3f9c},
    '{1'b1, 12'h7d8, 32'h0, 32'h3f97},
    '{1'b1, 12'h190, 32'h0, 32'h4000}};

  always #2.5 clk = ~clk;

  battery_capacity_model #(.SAVE_CYCLES(SAVE)) battery_capacity_model_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .apb_in(apb_in), .apb_out(apb_out),
    .conv_tick(conv_tick), .current_result(current_result), .temp_result(temp_result),
    .learn_valid(learn_valid), .learn_scale(learn_scale), .charge_count(charge_count),
    .age_scale(age_scale), .limits(limits), .full_now(full_now),
    .active_empty_now(ae_now), .standby_empty_now(se_now), .params_ready(params_ready));
  host_apb_model host_apb_model_i (.apb_out(apb_out), .clk(clk), .apb_in(apb_in));

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task wr(input logic [11:0] a, input logic [31:0] d);
    host_apb_model_i.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task tick(input logic signed [15:0] c);
    @(posedge clk);
    conv_tick <= 1'b1;
    current_result <= c;
    @(posedge clk);
    conv_tick <= 1'b0;
    @(negedge clk);
  endtask : tick

  task do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check(32'(age_scale), 32'h80, "scale in reset");
    check(32'(params_ready), 32'h0, "ready in reset");
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (100) if (params_ready !== 1'b1) @(posedge clk);
    check(32'(params_ready), 32'h1, "load done");
  endtask : do_reset

  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].crv) begin
        @(posedge clk);
        temp_result <= rows[i].a[10:0];
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(32'(full_now), rows[i].e, "full curve");
        check(32'(ae_now), 32'h100, "active curve");
        check(32'(se_now), 32'h0, "standby curve");
      end else begin
        wr(rows[i].a, rows[i].d);
        host_apb_model_i.xfer(1'b0, rows[i].a, 32'h0, rd, err);
        check(rd, rows[i].e, "readback");
      end
    end
    check({limits.sense_conductance, limits.charge_voltage_threshold, limits.min_charge_current_threshold, limits.empty_voltage_threshold}, 32'h32d7ff9a, "limits");
    check({8'h00, limits.empty_current_threshold, limits.ac}, 32'h001e0001, "limits");
    check({16'h0000, limits.full40}, 32'h0000041b, "full40 limit");
    $display("test rows done");
    wr(12'h000, 32'h100);
    tick(16'sh0000);
    check(32'(charge_count), 32'hff, "bias alone");
    tick(16'sh1080);
    check(32'(charge_count), 32'h100, "bias with current");
    wr(12'h000, 32'h0);
    tick(16'sh0000);
    check(32'(charge_count), 32'h0, "floor");
    $display("test bias done");
    wr(12'h008, 32'h0);
    wr(12'h000, 32'h100);
    repeat (40) tick(16'shf000);
    check(32'(charge_count), 32'hd8, "discharge");
    check(32'(age_scale), 32'h79, "aging step");
    $display("test aging done");
    @(posedge clk);
    learn_valid <= 1'b1;
    learn_scale <= 8'h70;
    @(posedge clk);
    learn_valid <= 1'b0;
    @(negedge clk);
    check(32'(age_scale), 32'h70, "learned scale");
    host_apb_model_i.xfer(1'b0, 12'h070, 32'h0, rd, err);
    check(32'(err), 32'h1, "unmapped read");
    $display("test learn done");
    wr(12'h008, 32'h7f);
    repeat (3 * SAVE) @(posedge clk);
    do_reset();
    check(32'(age_scale), 32'h70, "restored scale");
    wr(12'h000, 32'h0);
    tick(16'sh0f81);
    check(32'(charge_count), 32'h1, "restored bias");
    $display("test restore done");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule : test_battery_capacity_model
